// *** hdl/rtp_pkg.sv ***
package rtp_pkg;

   // processor cycle runs at ref_clk / PROC_DIV; status and data nibbles move once per processor cycle, the sampling clock twice
   localparam int          PROC_DIV       = 2;
   localparam int          DIV_W          = 1;
   localparam logic [DIV_W-1:0] DIV_LAST  = 1'h1;
   localparam logic [DIV_W-1:0] DIV_HALF  = 1'h1;

   // processor status codes
   localparam logic [3:0] ST_CONTINUE   = 4'h0;
   localparam logic [3:0] ST_BEGIN      = 4'h1;
   localparam logic [3:0] ST_RSVD_A     = 4'h2;
   localparam logic [3:0] ST_USER_ENTRY = 4'h3;
   localparam logic [3:0] ST_PULSE_WDD  = 4'h4;
   localparam logic [3:0] ST_TAKEN_BR   = 4'h5;
   localparam logic [3:0] ST_RSVD_B     = 4'h6;
   localparam logic [3:0] ST_RTE        = 4'h7;
   localparam logic [3:0] ST_MARK_BASE  = 4'h8;
   localparam logic [3:0] ST_EXCEPTION  = 4'hC;
   localparam logic [3:0] ST_EMU_ENTRY  = 4'hD;
   localparam logic [3:0] ST_STOPPED    = 4'hE;
   localparam logic [3:0] ST_HALTED     = 4'hF;

   // reset values of the trace outputs
   localparam logic [3:0] RST_STATUS    = 4'h0;
   localparam logic [3:0] RST_DEBUG_DATA_NIBBLE     = 4'h0;

   localparam int          FIFO_DEPTH     = 2;
   localparam int          DATA_W         = 32;

   typedef enum logic [2:0] {
      RTP_K_NORMAL = 3'h0,
      RTP_K_BRANCH = 3'h1,
      RTP_K_RTE    = 3'h2,
      RTP_K_PULSE  = 3'h3,
      RTP_K_WRITE_DEBUG_DATA_INSTRUCTION = 3'h4
   } rtp_kind_t;

   // one instruction start offered by the core; sizes are byte count minus one
   typedef struct packed {
      logic              begin_ins;
      rtp_kind_t         kind;
      logic              variant;
      logic              user_entry;
      logic [31:0]       target;
      logic [31:0]       operand;
      logic [1:0]        op_size_m1;
   } rtp_core_evt_t;

   typedef struct packed {
      logic              exc;
      logic              emu_exc;
      logic              stopped;
      logic              halted;
   } rtp_core_state_t;

   typedef struct packed {
      logic              trace_quiet_bit;
      logic              tgt_disp_en;
      logic [1:0]        tgt_bytes_m1;
      logic [3:0]        bkpt_status;
   } rtp_cfg_t;

   typedef struct packed {
      logic [31:0]       data;
      logic [1:0]        nbytes_m1;
   } rtp_entry_t;

   typedef struct packed {
      logic [3:0]        processor_status_nibble;
      logic [3:0]        debug_data_nibble;
      logic              trace_sample_clock;
   } rtp_trace_t;

endpackage : rtp_pkg

// *** hdl/rtp_capture_fifo.sv ***
`timescale 1ns/1ns
module rtp_capture_fifo
   import rtp_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic             push,
   input  rtp_pkg::rtp_entry_t   push_data,
   input  wire logic             pop,
   output rtp_pkg::rtp_entry_t   head,
   output logic                  head_valid,
   output logic                  full
);
   rtp_entry_t mem_ff [FIFO_DEPTH];
   rtp_entry_t nxt_mem [FIFO_DEPTH];
   logic       wr_ff, nxt_wr;
   logic       rd_ff, nxt_rd;
   logic [1:0] cnt_ff, nxt_cnt;
   logic       do_push, do_pop;

   // push while full is refused; the caller stalls the core instead
   always_comb begin
      do_pop  = pop && (cnt_ff != 2'h0);
      do_push = push && (cnt_ff != 2'h2);
      nxt_mem = mem_ff;
      nxt_wr  = wr_ff;
      nxt_rd  = rd_ff;
      nxt_cnt = cnt_ff;
      if (do_push) begin
         nxt_mem[wr_ff] = push_data;
         nxt_wr         = ~wr_ff;
      end
      if (do_pop) begin
         nxt_rd = ~rd_ff;
      end
      nxt_cnt = cnt_ff + {1'h0, do_push} - {1'h0, do_pop};
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wr_ff  <= 1'h0;
         rd_ff  <= 1'h0;
         cnt_ff <= 2'h0;
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            mem_ff[i] <= '0;
         end
      end else begin
         wr_ff  <= nxt_wr;
         rd_ff  <= nxt_rd;
         cnt_ff <= nxt_cnt;
         mem_ff <= nxt_mem;
      end
   end

   assign head       = mem_ff[rd_ff];
   assign head_valid = (cnt_ff != 2'h0);
   assign full       = (cnt_ff == 2'h2);

endmodule : rtp_capture_fifo

// *** hdl/rtp_trace_port.sv ***
`timescale 1ns/1ns
// Overview of operation
// - drive a delayed processor-rate sampling clock; the far side samples on its rise.
// - quiet bit freezes sampling clock, status and data nibbles.
// - two 4-bit nibbles, status and data, both move with the processor cycle.
// - later cycles of multi-cycle instructions show continue code 0000.
// - first cycle of ordinary instructions shows begin code 0001.
// - user-mode entry code 0011 follows the instruction that caused it.
// - trigger-pulse and write-data instructions show code 0100.
// - write-data instruction: code, byte-count marker, then operand of its own size.
// - taken branch shows code 0101.
// - capture targets only for variant jumps and returns from exception.
// - shown targets are 2, 3 or 4 bytes, marker 1001 to 1011.
// - data leaves least significant nibble first.
// - marker 1000..1011 precedes its 1..4 bytes by one cycle.
// - return from exception shows code 0111.
// - exception processing holds code 1100 until done.
// - emulator-entry exception processing holds code 1101 until done.
// - stopped state holds code 1110 until it is left.
// - halted state holds code 1111 until restart or reset.
// - captures wait in a two-entry 32-bit first-in first-out store.
// - core stalls on continue code while store is full and capture pending, and while user-mode code 0011 waits.
// - idle data nibble shows breakpoint status; both nibbles update each cycle.
module rtp_trace_port
   import rtp_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                srst,
   input  rtp_pkg::rtp_core_evt_t   core_evt,
   input  rtp_pkg::rtp_core_state_t core_state,
   input  rtp_pkg::rtp_cfg_t        cfg,
   output logic                     proc_en,
   output logic                     core_stall,
   output rtp_pkg::rtp_trace_t      trace
);
   import rtp_pkg::*;

   // a begin code that leads to a capture
   function automatic logic needs_capture(input rtp_core_evt_t e, input rtp_cfg_t c);
      logic hit;
      hit = 1'h0;
      if (e.begin_ins) begin
         unique case (e.kind)
            RTP_K_WRITE_DEBUG_DATA_INSTRUCTION: hit = 1'h1;
            RTP_K_BRANCH: hit = e.variant && c.tgt_disp_en;
            RTP_K_RTE:    hit = c.tgt_disp_en;
            default:      hit = 1'h0;
         endcase
      end
      return hit;
   endfunction : needs_capture

   function automatic logic [3:0] begin_code(input rtp_kind_t k);
      logic [3:0] code;
      code = ST_BEGIN;
      unique case (k)
         RTP_K_NORMAL: code = ST_BEGIN;
         RTP_K_BRANCH: code = ST_TAKEN_BR;
         RTP_K_RTE:    code = ST_RTE;
         RTP_K_PULSE:  code = ST_PULSE_WDD;
         RTP_K_WRITE_DEBUG_DATA_INSTRUCTION: code = ST_PULSE_WDD;
         default:      code = ST_BEGIN;
      endcase
      return code;
   endfunction : begin_code

   // processor-cycle divider
   logic [DIV_W-1:0] div_ff, nxt_div;
   logic             clk_hi_ff, nxt_clk_hi;

   always_comb begin
      nxt_div    = (div_ff == DIV_LAST) ? '0 : div_ff + 1'h1;
      // low on the edge that moves the nibbles, high one ref_clk later, so the rise sees settled data
      nxt_clk_hi = (nxt_div < DIV_HALF);
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         div_ff    <= '0;
         clk_hi_ff <= 1'h0;
      end else begin
         div_ff    <= nxt_div;
         clk_hi_ff <= nxt_clk_hi;
      end
   end

   assign proc_en = (div_ff == DIV_LAST);

   // capture store
   rtp_entry_t push_data, head;
   logic       push, pop, head_valid, fifo_full;
   logic       cap_req, accepted, multi, marker;

   rtp_capture_fifo u_fifo (
      .ref_clk    (ref_clk),
      .srst       (srst),
      .push       (push),
      .push_data  (push_data),
      .pop        (pop),
      .head       (head),
      .head_valid (head_valid),
      .full       (fifo_full)
   );

   // nibble shifter and pending user-mode entry
   logic [31:0] sh_ff, nxt_sh;
   logic [3:0]  left_ff, nxt_left;
   logic        user_pend_ff, nxt_user_pend;
   logic [3:0]  status_now, debug_data_nibble_now;
   rtp_trace_t  out_ff, nxt_out;

   // stall only for a full store or to slot the user-mode code; otherwise the core runs free
   always_comb begin
      cap_req    = needs_capture(core_evt, cfg);
      core_stall = (cap_req && fifo_full) || user_pend_ff;
      accepted   = proc_en && core_evt.begin_ins && !core_stall;
      multi      = core_state.halted || core_state.stopped
                   || core_state.emu_exc || core_state.exc;
      // a marker may only go when the shifter frees by the next cycle, so data stays back to back
      marker     = proc_en && head_valid && ((left_ff == 4'h0) || (left_ff == 4'h1))
                   && !multi && !user_pend_ff && !accepted;
      push       = accepted && cap_req;
      pop        = marker;
      push_data.data      = (core_evt.kind == RTP_K_WRITE_DEBUG_DATA_INSTRUCTION) ? core_evt.operand
                                                             : core_evt.target;
      push_data.nbytes_m1 = (core_evt.kind == RTP_K_WRITE_DEBUG_DATA_INSTRUCTION) ? core_evt.op_size_m1
                          : ((cfg.tgt_bytes_m1 == 2'h0) ? 2'h1 : cfg.tgt_bytes_m1);
   end

   always_comb begin
      nxt_sh        = sh_ff;
      nxt_left      = left_ff;
      nxt_user_pend = user_pend_ff;
      status_now    = ST_CONTINUE;
      debug_data_nibble_now     = cfg.bkpt_status;
      if (proc_en) begin
         if (left_ff != 4'h0) begin
            debug_data_nibble_now = sh_ff[3:0];
            nxt_sh    = {4'h0, sh_ff[31:4]};
            nxt_left  = left_ff - 4'h1;
         end
         if (marker) begin
            nxt_sh   = head.data;
            nxt_left = {1'h0, head.nbytes_m1, 1'h0} + 4'h2;
         end
         if (accepted && core_evt.user_entry) begin
            nxt_user_pend = 1'h1;
         end else if (user_pend_ff && !multi) begin
            nxt_user_pend = 1'h0;
         end
         if (core_state.halted) begin
            status_now = ST_HALTED;
         end else if (core_state.stopped) begin
            status_now = ST_STOPPED;
         end else if (core_state.emu_exc) begin
            status_now = ST_EMU_ENTRY;
         end else if (core_state.exc) begin
            status_now = ST_EXCEPTION;
         end else if (user_pend_ff) begin
            status_now = ST_USER_ENTRY;
         end else if (marker) begin
            status_now = ST_MARK_BASE | {2'h0, head.nbytes_m1};
         end else if (accepted) begin
            status_now = begin_code(core_evt.kind);
         end
      end
   end

   // the output stage freezes while quiet, so the far side sees a still port
   always_comb begin
      nxt_out = out_ff;
      if (!cfg.trace_quiet_bit) begin
         nxt_out.trace_sample_clock = clk_hi_ff;
         if (proc_en) begin
            nxt_out.processor_status_nibble = status_now;
            nxt_out.debug_data_nibble       = debug_data_nibble_now;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sh_ff        <= '0;
         left_ff      <= 4'h0;
         user_pend_ff <= 1'h0;
         out_ff       <= '{processor_status_nibble: RST_STATUS,
                           debug_data_nibble:       RST_DEBUG_DATA_NIBBLE,
                           trace_sample_clock:      1'h0};
      end else begin
         sh_ff        <= nxt_sh;
         left_ff      <= nxt_left;
         user_pend_ff <= nxt_user_pend;
         out_ff       <= nxt_out;
      end
   end

   assign trace = out_ff;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   quiet_freeze_a: assert property (
      cfg.trace_quiet_bit && $past(cfg.trace_quiet_bit) |-> $stable(trace))
      else $error("trace port moved while quiet");

   no_reserved_a: assert property (
      trace.processor_status_nibble != ST_RSVD_A && trace.processor_status_nibble != ST_RSVD_B)
      else $error("reserved status code driven");

   marker_data_a: assert property (
      marker |=> left_ff == {1'h0, $past(head.nbytes_m1), 1'h0} + 4'h2)
      else $error("marker not followed by its byte count of nibbles");

   halt_code_a: assert property (
      proc_en && core_state.halted && !cfg.trace_quiet_bit
      |=> trace.processor_status_nibble == ST_HALTED)
      else $error("halted code not shown");

   stall_full_a: assert property (
      cap_req && fifo_full |-> core_stall)
      else $error("capture into full store without stall");

   free_run_a: assert property (
      !fifo_full && !user_pend_ff |-> !core_stall)
      else $error("core stalled without cause");

   stall_cont_a: assert property (
      proc_en && core_stall && !multi && !user_pend_ff && !marker && !cfg.trace_quiet_bit
      |=> trace.processor_status_nibble == ST_CONTINUE)
      else $error("stall cycle not shown as continue");

   reset_idle_a: assert property (
      $past(srst) |-> trace.processor_status_nibble == RST_STATUS
                      && trace.debug_data_nibble == RST_DEBUG_DATA_NIBBLE && left_ff == 4'h0)
      else $error("trace port not idle after reset");

   lsn_first_a: assert property (
      proc_en && left_ff != 4'h0 && !cfg.trace_quiet_bit
      |=> trace.debug_data_nibble == $past(sh_ff[3:0]))
      else $error("data nibble out of order");

   sample_clk_a: assert property (
      proc_en && !cfg.trace_quiet_bit ##1 !cfg.trace_quiet_bit
      |-> !trace.trace_sample_clock ##1 trace.trace_sample_clock)
      else $error("sampling clock not delayed behind data");

   user_code_a: assert property (
      proc_en && user_pend_ff && !multi && !cfg.trace_quiet_bit
      |=> trace.processor_status_nibble == ST_USER_ENTRY)
      else $error("user-mode entry code not shown");

   begin_code_a: assert property (
      accepted && core_evt.kind == RTP_K_NORMAL && !multi && !cfg.trace_quiet_bit
      |=> trace.processor_status_nibble == ST_BEGIN)
      else $error("begin code not shown");

   branch_code_a: assert property (
      accepted && core_evt.kind == RTP_K_BRANCH && !multi && !cfg.trace_quiet_bit
      |=> trace.processor_status_nibble == ST_TAKEN_BR)
      else $error("taken branch code not shown");

   rte_code_a: assert property (
      accepted && core_evt.kind == RTP_K_RTE && !multi && !cfg.trace_quiet_bit
      |=> trace.processor_status_nibble == ST_RTE)
      else $error("return from exception code not shown");

   pulse_code_a: assert property (
      accepted && (core_evt.kind == RTP_K_PULSE || core_evt.kind == RTP_K_WRITE_DEBUG_DATA_INSTRUCTION)
      && !multi && !cfg.trace_quiet_bit
      |=> trace.processor_status_nibble == ST_PULSE_WDD)
      else $error("pulse or write-data code not shown");

   exc_code_a: assert property (
      proc_en && core_state.exc && !core_state.emu_exc && !core_state.stopped
      && !core_state.halted && !cfg.trace_quiet_bit
      |=> trace.processor_status_nibble == ST_EXCEPTION)
      else $error("exception code not shown");

   emu_code_a: assert property (
      proc_en && core_state.emu_exc && !core_state.stopped && !core_state.halted
      && !cfg.trace_quiet_bit
      |=> trace.processor_status_nibble == ST_EMU_ENTRY)
      else $error("emulator entry code not shown");

   stop_code_a: assert property (
      proc_en && core_state.stopped && !core_state.halted && !cfg.trace_quiet_bit
      |=> trace.processor_status_nibble == ST_STOPPED)
      else $error("stopped code not shown");

   continue_code_a: assert property (
      proc_en && !accepted && !marker && !multi && !user_pend_ff && !cfg.trace_quiet_bit
      |=> trace.processor_status_nibble == ST_CONTINUE)
      else $error("idle cycle not shown as continue");

   idle_data_a: assert property (
      proc_en && left_ff == 4'h0 && !cfg.trace_quiet_bit
      |=> trace.debug_data_nibble == $past(cfg.bkpt_status))
      else $error("idle data nibble not breakpoint status");

   capture_kind_a: assert property (
      push |-> core_evt.kind == RTP_K_WRITE_DEBUG_DATA_INSTRUCTION || core_evt.kind == RTP_K_RTE
               || (core_evt.kind == RTP_K_BRANCH && core_evt.variant))
      else $error("capture for a kind that shows no data");

endmodule : rtp_trace_port

// *** bench/rtp_dev_system.sv ***
`timescale 1ns/1ns
module rtp_dev_system
   import rtp_pkg::*;
(
   input  rtp_pkg::rtp_trace_t trace,
   output logic [7:0]          smp,
   output int                  smp_count
);
   initial smp_count = 0;
   // nibbles are settled for the whole high half, so the rise is a safe sampling point
   always @(posedge trace.trace_sample_clock) begin
      smp = {trace.processor_status_nibble, trace.debug_data_nibble};
      smp_count++;
   end
endmodule : rtp_dev_system

// *** bench/tb_realtime_trace_port.sv ***
`timescale 1ns/1ns
module tb_realtime_trace_port;
   import rtp_pkg::*;
   logic            ref_clk = 1'b0;
   logic            srst = 1'b1;
   rtp_core_evt_t   core_evt = '0;
   rtp_core_state_t core_state = '0;
   rtp_cfg_t        cfg = '0;
   logic            proc_en;
   logic            core_stall;
   rtp_trace_t      trace;
   logic [7:0]      smp;
   int              smp_count;
   logic [7:0]      notes[$];
   logic            busy = 1'b0;
   logic [3:0]      bk;
   logic [31:0]     v;
   logic [31:0]     frozen;
   int              failures = 0;
   int              comparisons = 0;
   int              seed = 32'h7c3f;
   int              stalls = 0;
   int              i;
   int              nb;
   always #2 ref_clk = ~ref_clk;
   rtp_trace_port i_dut (.ref_clk(ref_clk), .srst(srst), .core_evt(core_evt),
      .core_state(core_state), .cfg(cfg), .proc_en(proc_en),
      .core_stall(core_stall), .trace(trace));
   rtp_dev_system i_dev (.trace(trace), .smp(smp), .smp_count(smp_count));
   task automatic end_of_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t mismatch exp %h got %h", $time, exp, got);
      end
   endtask : check
   task automatic timeout();
      failures++;
      $display("ERROR %0t wait limit reached", $time);
      end_of_test();
   endtask : timeout
   task automatic note(input logic [3:0] st);
      notes.push_back({st, bk});
   endtask : note
   task automatic note_bytes(input logic [31:0] val, input int n);
      for (int k = 0; k < 2 * n; k++) notes.push_back({ST_CONTINUE, val[4*k+:4]});
   endtask : note_bytes
   // the offer is held until an edge with proc_en high and no stall takes it
   task automatic offer(input rtp_kind_t kd, input logic var_b, input logic usr,
                        input logic [1:0] sz);
      int n;
      @(negedge ref_clk);
      v = $random(seed);
      core_evt = {1'b1, kd, var_b, usr, v, v, sz};
      #1;
      for (n = 0; n < 100 && !(proc_en === 1'b1 && core_stall === 1'b0); n++) begin
         if (core_stall === 1'b1) stalls++;
         @(negedge ref_clk);
         #1;
      end
      if (n == 100) timeout();
      @(negedge ref_clk);
      core_evt.begin_ins = 1'b0;
   endtask : offer
   task automatic drain();
      int n;
      for (n = 0; n < 300 && (notes.size() > 0 || busy); n++) @(negedge ref_clk);
      if (n == 300) timeout();
      repeat (10) @(negedge ref_clk);
   endtask : drain
   // a run of notes starts at the first non-continue sample, then goes cycle by cycle
   always @(smp_count) begin
      check(1, smp[7:4] !== ST_RSVD_A && smp[7:4] !== ST_RSVD_B);
      if (notes.size() > 0 && (busy || smp[7:4] !== ST_CONTINUE)) begin
         busy = notes.size() > 1;
         check(notes.pop_front(), smp);
      end
   end
   initial begin
      bk = 4'($random(seed));
      cfg.bkpt_status = bk;
      cfg.tgt_disp_en = 1'b1;
      repeat (8) @(negedge ref_clk);
      check(0, 32'(trace));
      srst = 1'b0;
      offer(RTP_K_NORMAL, 1'b0, 1'b0, 2'h0);
      note(ST_BEGIN);
      drain();
      offer(RTP_K_NORMAL, 1'b0, 1'b1, 2'h0);
      note(ST_BEGIN);
      note(ST_USER_ENTRY);
      drain();
      $display("test done: begin and user entry");
      for (i = 0; i < 4; i++) begin
         cfg.tgt_bytes_m1 = 2'(i);
         nb = (i == 0) ? 2 : i + 1;
         offer(RTP_K_BRANCH, 1'b1, 1'b0, 2'h0);
         note(ST_TAKEN_BR);
         note(ST_MARK_BASE + 4'(nb - 1));
         note_bytes(v, nb);
         drain();
      end
      offer(RTP_K_RTE, 1'b1, 1'b0, 2'h0);
      note(ST_RTE);
      note(ST_MARK_BASE + 4'h3);
      note_bytes(v, 4);
      drain();
      offer(RTP_K_BRANCH, 1'b0, 1'b0, 2'h0);
      note(ST_TAKEN_BR);
      drain();
      $display("test done: branch targets");
      cfg.tgt_disp_en = 1'b0;
      offer(RTP_K_PULSE, 1'b0, 1'b0, 2'h0);
      note(ST_PULSE_WDD);
      drain();
      // operand display must not depend on target display being enabled
      for (i = 0; i < 4; i++) begin
         offer(RTP_K_WRITE_DEBUG_DATA_INSTRUCTION, 1'b0, 1'b0, 2'(i));
         note(ST_PULSE_WDD);
         note(ST_MARK_BASE + 4'(i));
         note_bytes(v, i + 1);
         drain();
      end
      check(0, stalls);
      $display("test done: pulse and operand");
      for (i = 0; i < 4; i++) begin
         #1;
         for (nb = 0; nb < 4 && proc_en !== 1'b1; nb++) begin
            @(negedge ref_clk);
            #1;
         end
         if (nb == 4) timeout();
         repeat (3) note(ST_EXCEPTION + 4'(i));
         core_state = 4'(8 >> i);
         repeat (5) @(negedge ref_clk);
         core_state = '0;
         drain();
      end
      $display("test done: held states");
      cfg.tgt_disp_en = 1'b1;
      for (i = 0; i < 4; i++) offer(RTP_K_BRANCH, 1'b1, 1'b0, 2'h0);
      check(1, stalls > 0);
      repeat (200) @(negedge ref_clk);
      $display("test done: store full");
      offer(RTP_K_BRANCH, 1'b1, 1'b0, 2'h0);
      repeat (6) @(negedge ref_clk);
      srst = 1'b1;
      repeat (2) @(negedge ref_clk);
      check(0, 32'(trace));
      srst = 1'b0;
      repeat (4) @(negedge ref_clk);
      check({ST_CONTINUE, bk}, 32'(trace[8:1]));
      $display("test done: reset mid-transfer");
      cfg.trace_quiet_bit = 1'b1;
      repeat (4) @(negedge ref_clk);
      nb = smp_count;
      frozen = 32'(trace);
      offer(RTP_K_BRANCH, 1'b1, 1'b0, 2'h0);
      repeat (20) @(negedge ref_clk);
      check(nb, smp_count);
      check(frozen, 32'(trace));
      $display("test done: quiet");
      end_of_test();
   end
endmodule : tb_realtime_trace_port
